/* File: spi_event_regs.v */
// SPI buffer window, baud divisor and interrupt event registers, with
// a slave-mode serial shifter that feeds the element counts.
// Assumes an AXI4-Lite master on CLK, an SPI host driving SCK, MOSI and
// SS_N from its own clock, and a clock generator reading BAUD_DIV.
//
// Contract
// - Low buffer register reaches FIFO low half
// - High buffer register holds upper half, reset zero
// - Thirteen-bit baud divisor, read/write, reset zero
// - Frame fault event when its enable set
// - Activity status event when its enable set
// - Underrun event when its enable set
// - Shifter empty event when its enable set
// - Receive overflow event when its enable set
// - Receive empty event when its enable set
// - Transmit empty event when its enable set
// - Transmit full event when its enable set
// - Receive full event when its enable set
// - Receive watermark when level <= receive count
// - Transmit watermark when level equals transmit count
// - Keep six-bit receive element count
// - Keep six-bit transmit element count
// - Underrun flag cleared while module off
`timescale 1ns/1ps
`include "spi_event_map.vh"

module spi_event_regs #(
  parameter ADDR_W = 16,
  parameter DEPTH_LOG2 = 6
) (
  input wire CLK,
  input wire RST,
  input wire [ADDR_W-1:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  input wire [ADDR_W-1:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  input wire SCK,
  input wire MOSI,
  input wire SS_N,
  output wire MISO,
  output wire [12:0] BAUD_DIV,
  output wire IRQ
);

  localparam DEPTH = 1 << DEPTH_LOG2;
  // ----------------------------------------------------------------
  // Bus slave, software registers, buffers and link state
  // ----------------------------------------------------------------
  reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg aw_held_ff, w_held_ff;
  reg [13:0] aw_idx_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;
  reg [15:0] tx_high_ff, rx_high_ff;
  reg [12:0] baud_ff;
  reg [15:0] evt_en_ff, wmark_ff, irq_stat_ff, irq_mask_ff;
  reg module_on_ff, irq_ff;
  reg [31:0] tx_mem [0:DEPTH-1];
  reg [31:0] rx_mem [0:DEPTH-1];
  reg [DEPTH_LOG2-1:0] tx_wr_ff, tx_rd_ff, rx_wr_ff, rx_rd_ff;
  reg [5:0] tx_cnt_ff, rx_cnt_ff;
  reg [2:0] sck_sync_ff, ss_sync_ff;
  reg [1:0] mosi_sync_ff;
  reg [31:0] shift_tx_ff, shift_rx_ff;
  reg [4:0] bit_cnt_ff;
  reg miso_ff, underrun_ff, overflow_ff, frame_ff, word_real_ff;
  wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire [13:0] ar_idx = ARADDR[15:2];
  wire do_read = ARVALID & arready_ff;
  wire [15:0] wlo = wdata_ff[15:0];
  // Byte-lane merge for the 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] strb;
    begin
      merge16 = {strb[1] ? nw[15:8] : old[15:8],
                 strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction
  wire [15:0] baud_wr = merge16({3'h0, baud_ff}, wlo, wstrb_ff[1:0]);

  // ----------------------------------------------------------------
  // Flags and link edges
  // ----------------------------------------------------------------
  wire tx_empty = (tx_cnt_ff == `RST_CNT);
  wire rx_empty = (rx_cnt_ff == `RST_CNT);
  wire tx_full = (tx_cnt_ff == `CNT_FULL);
  wire rx_full = (rx_cnt_ff == `CNT_FULL);
  wire ss_low = ~ss_sync_ff[1];
  wire ss_fall = ss_sync_ff[2] & ~ss_sync_ff[1];
  wire ss_rise = ~ss_sync_ff[2] & ss_sync_ff[1];
  wire sck_rise = ~sck_sync_ff[2] & sck_sync_ff[1];
  wire sck_fall = sck_sync_ff[2] & ~sck_sync_ff[1];
  wire active = module_on_ff & ss_low;
  wire activity_flag = active;
  wire shifter_empty_flag = tx_empty & (bit_cnt_ff == 5'h00);

  // Peek at a boundary, pop at the first rise: a frame ending on a word boundary loses no word
  wire tx_take = module_on_ff &
                 (ss_fall | (active & sck_fall & bit_cnt_ff == 5'h00));
  wire word_start = active & sck_rise & (bit_cnt_ff == 5'h00);
  wire tx_pop = word_start & word_real_ff;
  wire rx_done = active & sck_rise & (bit_cnt_ff == `WORD_LAST);
  wire rx_push = rx_done & ~rx_full;
  wire tx_push = do_write & (aw_idx_ff == `IDX_FIFO_LOW) & ~tx_full;
  wire rx_pop = do_read & (ar_idx == `IDX_FIFO_LOW) & ~rx_empty;

  wire rx_wm = wmark_ff[`BIT_RX_WM_EN] & (wmark_ff[13:8] <= rx_cnt_ff);
  wire tx_wm = wmark_ff[`BIT_TX_WM_EN] & (wmark_ff[5:0] == tx_cnt_ff);

  // Raw flag vector laid out like the event enable register
  reg [15:0] raw_flags;
  always @* begin
    raw_flags = 16'h0000;
    raw_flags[`BIT_FRAME] = frame_ff;
    raw_flags[`BIT_ACTIVITY] = activity_flag;
    raw_flags[`BIT_UNDERRUN] = underrun_ff;
    raw_flags[`BIT_SHIFTER] = shifter_empty_flag;
    raw_flags[`BIT_OVERFLOW] = overflow_ff;
    raw_flags[`BIT_RX_EMPTY] = rx_empty;
    raw_flags[`BIT_TX_EMPTY] = tx_empty;
    raw_flags[`BIT_TX_FULL] = tx_full;
    raw_flags[`BIT_RX_FULL] = rx_full;
  end

  // enable gating of each status flag
  wire [15:0] flag_events = raw_flags & evt_en_ff & `EVT_EN_MASK;
  wire [15:0] events = flag_events |
                       {rx_wm, tx_wm, 14'h0000};

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 14'h0000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else begin
      if (AWVALID & awready_ff) begin
        aw_idx_ff <= AWADDR[15:2];
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (WVALID & wready_ff) begin
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        case (aw_idx_ff)
          `IDX_FIFO_LOW, `IDX_FIFO_HIGH, `IDX_BAUD, `IDX_EVT_EN,
          `IDX_WMARK, `IDX_CTRL, `IDX_FLAGS, `IDX_IRQ_STAT,
          `IDX_IRQ_MASK: bresp_ff <= `RESP_OKAY;
          default: bresp_ff <= `RESP_SLVERR;
        endcase
      end
      // Ready returns only after the response is accepted
      if (bvalid_ff & BREADY) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      tx_high_ff <= `RST_HALF;
      baud_ff <= `RST_BAUD;
      evt_en_ff <= `RST_EVT_EN;
      wmark_ff <= `RST_WMARK;
      irq_mask_ff <= `RST_IRQ;
      module_on_ff <= 1'b0;
    end else if (do_write) begin
      case (aw_idx_ff)
        // upper half staged for the next low write
        `IDX_FIFO_HIGH: tx_high_ff <= merge16(tx_high_ff, wlo,
                                              wstrb_ff[1:0]);
        // divisor; left to software while the module is on
        `IDX_BAUD: baud_ff <= baud_wr[12:0];
        `IDX_EVT_EN: evt_en_ff <= merge16(evt_en_ff, wlo,
                                          wstrb_ff[1:0]) & `EVT_EN_MASK;
        `IDX_WMARK: wmark_ff <= merge16(wmark_ff, wlo,
                                        wstrb_ff[1:0]) & `WMARK_MASK;
        `IDX_IRQ_MASK: irq_mask_ff <= merge16(irq_mask_ff, wlo,
                                        wstrb_ff[1:0]) & `IRQ_MASK_BITS;
        `IDX_CTRL: if (wstrb_ff[0]) begin
          module_on_ff <= wlo[`BIT_MODULE_ON];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel; a low buffer read pops the receive buffer
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RESP_OKAY;
      rx_high_ff <= `RST_HALF;
    end else begin
      if (do_read) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= `RESP_OKAY;
        rdata_ff <= 32'h00000000;
        case (ar_idx)
          // low half of the head word; upper half kept for later
          `IDX_FIFO_LOW: if (~rx_empty) begin
            rdata_ff[15:0] <= rx_mem[rx_rd_ff][15:0];
            rx_high_ff <= rx_mem[rx_rd_ff][31:16];
          end
          `IDX_FIFO_HIGH: rdata_ff[15:0] <= rx_high_ff;
          `IDX_BAUD: rdata_ff[12:0] <= baud_ff;
          `IDX_EVT_EN: rdata_ff[15:0] <= evt_en_ff;
          `IDX_WMARK: rdata_ff[15:0] <= wmark_ff;
          `IDX_CTRL: rdata_ff[`BIT_MODULE_ON] <= module_on_ff;
          `IDX_FLAGS: rdata_ff <= {2'h0, rx_cnt_ff, 2'h0, tx_cnt_ff,
                                   raw_flags};
          `IDX_IRQ_STAT: rdata_ff[15:0] <= irq_stat_ff;
          `IDX_IRQ_MASK: rdata_ff[15:0] <= irq_mask_ff;
          default: rresp_ff <= `RESP_SLVERR;
        endcase
      end
      if (rvalid_ff & RREADY) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky interrupt status; a new event wins over the read clear
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      irq_stat_ff <= `RST_IRQ;
      irq_ff <= 1'b0;
    end else begin
      if (do_read & (ar_idx == `IDX_IRQ_STAT)) begin
        irq_stat_ff <= events;
      end else begin
        irq_stat_ff <= irq_stat_ff | events;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Buffer storage; no reset needed on data words
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    // full word written by the low half
    if (tx_push) begin
      tx_mem[tx_wr_ff] <= {tx_high_ff, merge16(16'h0000, wlo,
                                                wstrb_ff[1:0])};
    end
    if (rx_push) begin
      rx_mem[rx_wr_ff] <= {shift_rx_ff[30:0], mosi_sync_ff[1]};
    end
  end

  // ----------------------------------------------------------------
  // Element counts and pointers
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      tx_wr_ff <= {DEPTH_LOG2{1'b0}};
      tx_rd_ff <= {DEPTH_LOG2{1'b0}};
      rx_wr_ff <= {DEPTH_LOG2{1'b0}};
      rx_rd_ff <= {DEPTH_LOG2{1'b0}};
      tx_cnt_ff <= `RST_CNT;
      rx_cnt_ff <= `RST_CNT;
    end else begin
      if (tx_push) tx_wr_ff <= tx_wr_ff + 1'b1;
      if (tx_pop) tx_rd_ff <= tx_rd_ff + 1'b1;
      if (rx_push) rx_wr_ff <= rx_wr_ff + 1'b1;
      if (rx_pop) rx_rd_ff <= rx_rd_ff + 1'b1;
      if (tx_push & ~tx_pop) tx_cnt_ff <= tx_cnt_ff + 6'h01;
      else if (tx_pop & ~tx_push) tx_cnt_ff <= tx_cnt_ff - 6'h01;
      if (rx_push & ~rx_pop) rx_cnt_ff <= rx_cnt_ff + 6'h01;
      else if (rx_pop & ~rx_push) rx_cnt_ff <= rx_cnt_ff - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers; stage 0 feeds only stage 1
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      sck_sync_ff <= 3'h0;
      ss_sync_ff <= 3'h7;
      mosi_sync_ff <= 2'h0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[1:0], SCK};
      ss_sync_ff <= {ss_sync_ff[1:0], SS_N};
      mosi_sync_ff <= {mosi_sync_ff[0], MOSI};
    end
  end

  // ----------------------------------------------------------------
  // Slave shifter, mode 0, MSB first, 32-bit words
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      shift_tx_ff <= 32'h00000000;
      shift_rx_ff <= 32'h00000000;
      bit_cnt_ff <= 5'h00;
      miso_ff <= 1'b0;
      underrun_ff <= 1'b0;
      overflow_ff <= 1'b0;
      frame_ff <= 1'b0;
      word_real_ff <= 1'b0;
    end else begin
      if (~active) begin
        bit_cnt_ff <= 5'h00;
      end else if (sck_rise) begin
        shift_rx_ff <= {shift_rx_ff[30:0], mosi_sync_ff[1]};
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
      // Empty buffer at a word boundary sends zeros
      if (tx_take) begin
        shift_tx_ff <= tx_empty ? 32'h00000000 : tx_mem[tx_rd_ff];
        word_real_ff <= ~tx_empty;
      end else if (active & sck_fall) begin
        shift_tx_ff <= {shift_tx_ff[30:0], 1'b0};
      end
      miso_ff <= active & shift_tx_ff[31];
      // underrun cleared while the module is off
      if (~module_on_ff) underrun_ff <= 1'b0;
      else if (word_start & ~word_real_ff) underrun_ff <= 1'b1;
      // Overflow drops the word; the next pop clears the flag
      if (rx_done & rx_full) overflow_ff <= 1'b1;
      else if (rx_pop) overflow_ff <= 1'b0;
      // Select released mid-word is a frame fault
      if (module_on_ff & ss_rise & (bit_cnt_ff != 5'h00)) begin
        frame_ff <= 1'b1;
      end else if (do_read & (ar_idx == `IDX_FLAGS) | ~module_on_ff) begin
        frame_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flip-flops
  // ----------------------------------------------------------------
  assign AWREADY = awready_ff;
  assign WREADY = wready_ff;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;
  assign MISO = miso_ff;
  assign BAUD_DIV = baud_ff;
  assign IRQ = irq_ff;

endmodule

/* File: spi_event_map.vh */
// Register map, field positions and reset values of the SPI buffer,
// baud divisor and interrupt event block.
// Assumes 32-bit AXI4-Lite data with a 16-bit byte address.
`ifndef SPI_EVENT_MAP_VH
`define SPI_EVENT_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_FIFO_LOW 14'h041C
`define IDX_FIFO_HIGH 14'h041E
`define IDX_BAUD 14'h0420
`define IDX_EVT_EN 14'h0424
`define IDX_WMARK 14'h0426
`define IDX_CTRL 14'h0430
`define IDX_FLAGS 14'h0431
`define IDX_IRQ_STAT 14'h0432
`define IDX_IRQ_MASK 14'h0433

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_FRAME 12
`define BIT_ACTIVITY 11
`define BIT_UNDERRUN 8
`define BIT_SHIFTER 7
`define BIT_OVERFLOW 6
`define BIT_RX_EMPTY 5
`define BIT_TX_EMPTY 3
`define BIT_TX_FULL 1
`define BIT_RX_FULL 0
`define BIT_RX_WM_EN 15
`define BIT_TX_WM_EN 7
`define BIT_RX_WM_IRQ 15
`define BIT_TX_WM_IRQ 14
`define BIT_MODULE_ON 0
`define EVT_EN_MASK 16'h19EB
`define WMARK_MASK 16'hBFBF
`define IRQ_MASK_BITS 16'hD9EB

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_HALF 16'h0000
`define RST_BAUD 13'h0000
`define RST_EVT_EN 16'h0000
`define RST_WMARK 16'h0000
`define RST_IRQ 16'h0000
`define RST_CNT 6'h00

// ----------------------------------------------------------------
// Bus answers and link constants
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_LAST 5'h1F
`define CNT_FULL 6'h3F

`endif

/* File: spi_event_regs_asserts.sv */
// Checker for the SPI event register block, bound to its top module.
// Assumes only the bus handshake, divisor and interrupt ports.
`timescale 1ns/1ps

module spi_event_regs_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [12:0] BAUD_DIV,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ----
  // Bus answers stand and come on time
  // ----
  property p_b_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer changed before taken");
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed before taken");
  property p_b_lat;
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write answer late");
  property p_r_lat;
    ARVALID && ARREADY |=> RVALID;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  // Only one transfer of each kind under way
  property p_w_busy;
    BVALID |-> !AWREADY && !WREADY;
  endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("new write taken while answer pending");
  property p_r_busy;
    RVALID |-> !ARREADY;
  endproperty
  a_r_busy: assert property (p_r_busy)
    else $error("new read taken while answer pending");

  // ----
  // Divisor moves and interrupt falls only with bus traffic
  // ----
  property p_baud;
    !$past(RST) && $changed(BAUD_DIV) |-> !AWREADY;
  endproperty
  a_baud: assert property (p_baud)
    else $error("divisor changed without a write");
  // Status is sticky, so only a read or a mask write can drop the line
  property p_irq_fall;
    $fell(IRQ) |-> !$past(ARREADY) || !$past(AWREADY);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without bus access");
endmodule

bind spi_event_regs spi_event_regs_chk spi_event_regs_chk_i (.CLK, .RST,
  .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID,
  .ARREADY, .RDATA, .RVALID, .RREADY, .BAUD_DIV, .IRQ);

/* File: spi_host_model.sv */
// Behavioural SPI host: mode 0, MSB first, 32-bit words.
// Assumes the block samples SCK, MOSI and SS_N with its own clock.
`timescale 1ns/1ps

module spi_host_model (
  output logic SCK,
  output logic MOSI,
  output logic SS_N,
  input wire logic MISO
);
  localparam int half_ns = 200;

  // Idle: clock low and still, not selected
  initial begin
    SCK = 1'b0;
    MOSI = 1'b0;
    SS_N = 1'b1;
  end

  // One frame; fewer than 32 bits cuts the word short on purpose
  task automatic xfer(input logic [31:0] tx, input int nbits,
      output logic [31:0] rx);
    rx = 32'h0;
    #17;
    SS_N = 1'b0;
    #(2 * half_ns);
    for (int i = 31; i > 31 - nbits; i--) begin
      MOSI = tx[i];
      #half_ns;
      SCK = 1'b1;
      #(half_ns - 1);
      rx = {rx[30:0], MISO}; // Late sample: MISO lags the falling edge
      #1;
      SCK = 1'b0;
    end
    #(2 * half_ns);
    SS_N = 1'b1;
    MOSI = ~MOSI; // Released line shows no stale bit
  endtask
endmodule

/* File: spi_event_regs_tb.sv */
// Self-checking bench for the SPI event register block over AXI4-Lite.
// Assumes the map header, host model and checker are compiled first.
`timescale 1ns/1ps
`include "spi_event_map.vh"

module spi_event_regs_tb;
  logic CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [15:0] AWADDR, ARADDR;
  logic [31:0] WDATA, rdat, rx;
  logic [3:0] WSTRB;
  logic [1:0] resp;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, SCK, MOSI, SS_N, MISO, IRQ;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [12:0] BAUD_DIV;
  int miscompares = 0;
  int checks = 0;
  int ev[3] = '{3, 5, 7};
  localparam logic [31:0] ones = 32'hFFFF_FFFF;

  spi_event_regs spi_event_regs_i (.CLK, .RST, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .SCK, .MOSI, .SS_N,
    .MISO, .BAUD_DIV, .IRQ);
  spi_host_model spi_host_model_i (.SCK, .MOSI, .SS_N, .MISO);

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // ----
  // Compare, verdict and bus tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A wait that ran out ends the run as a failure
  task automatic limit(input int n);
    if (n >= 64) begin
      miscompares++;
      finish_test;
    end
  endtask

  task automatic axi_wr(input logic [13:0] idx, input logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    AWADDR <= {idx, 2'b00};
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID && n < 64);
    limit(n);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic axi_rd(input logic [13:0] idx, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    ARADDR <= {idx, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID && n < 64);
    limit(n);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    axi_wr(idx, d, resp);
    chk({30'h0, resp}, {30'h0, `RESP_OKAY});
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [31:0] m,
      input logic [31:0] e);
    axi_rd(idx, rdat, resp);
    chk({30'h0, resp}, {30'h0, `RESP_OKAY});
    chk(rdat & m, e);
  endtask

  // Read the sticky status once so only live events remain
  task automatic clr_stat;
    axi_rd(`IDX_IRQ_STAT, rdat, resp);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    RST = 1'b1;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    AWADDR = 16'h0;
    ARADDR = 16'h0;
    WDATA = 32'h0;
    WSTRB = 4'h3;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rdc(`IDX_FIFO_HIGH, ones, 32'h0);
    rdc(`IDX_EVT_EN, ones, 32'h0);
    rdc(`IDX_WMARK, ones, 32'h0);
    rdc(`IDX_BAUD, ones, 32'h0);
    wr(`IDX_BAUD, ones);
    rdc(`IDX_BAUD, ones, 32'h1FFF);
    chk({19'h0, BAUD_DIV}, 32'h1FFF);
    wr(`IDX_EVT_EN, ones);
    rdc(`IDX_EVT_EN, ones, {16'h0, `EVT_EN_MASK});
    wr(`IDX_WMARK, ones);
    rdc(`IDX_WMARK, ones, {16'h0, `WMARK_MASK});
    wr(`IDX_WMARK, 32'h0);
    // Hole in the map answers with an error and no data
    axi_rd(14'h041D, rdat, resp);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    chk(rdat, 32'h0);
    // Level events one at a time, seen in status and on the line
    wr(`IDX_CTRL, 32'h1);
    wr(`IDX_IRQ_MASK, ones);
    foreach (ev[i]) begin
      wr(`IDX_EVT_EN, 32'h1 << ev[i]);
      clr_stat;
      rdc(`IDX_IRQ_STAT, ones, 32'h1 << ev[i]);
      chk({31'h0, IRQ}, 32'h1);
    end
    wr(`IDX_IRQ_MASK, 32'h0);
    repeat (3) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    wr(`IDX_EVT_EN, 32'h0);
    clr_stat;
    rdc(`IDX_IRQ_STAT, ones, 32'h0);
    // Watermarks: receive at level one, transmit at level zero
    wr(`IDX_WMARK, 32'h8180);
    clr_stat;
    rdc(`IDX_IRQ_STAT, 32'hC000, 32'h4000);
    wr(`IDX_FIFO_HIGH, 32'hA5C3);
    wr(`IDX_FIFO_LOW, 32'h1E96);
    clr_stat;
    rdc(`IDX_IRQ_STAT, 32'hC000, 32'h0);
    rdc(`IDX_FLAGS, 32'h3F3F_0000, 32'h0001_0000);
    spi_host_model_i.xfer(32'h3C5A_0FF0, 32, rx);
    chk(rx, 32'hA5C3_1E96);
    clr_stat;
    rdc(`IDX_IRQ_STAT, 32'hC000, 32'hC000);
    rdc(`IDX_FLAGS, 32'h3F3F_0000, 32'h0100_0000);
    rdc(`IDX_FIFO_LOW, ones, 32'h0FF0);
    rdc(`IDX_FIFO_HIGH, ones, 32'h3C5A);
    // Empty transmit side sends zeros; underrun lasts until module off
    wr(`IDX_EVT_EN, 32'h0100);
    spi_host_model_i.xfer(32'h00FF, 32, rx);
    chk(rx, 32'h0);
    rdc(`IDX_FIFO_LOW, ones, 32'h00FF);
    rdc(`IDX_FLAGS, 32'h0100, 32'h0100);
    rdc(`IDX_IRQ_STAT, 32'h0100, 32'h0100);
    wr(`IDX_CTRL, 32'h0);
    rdc(`IDX_FLAGS, 32'h0100, 32'h0);
    wr(`IDX_CTRL, 32'h1);
    // Cut frame: fault and activity events, partial word dropped
    wr(`IDX_EVT_EN, 32'h1800);
    clr_stat;
    spi_host_model_i.xfer(ones, 8, rx);
    // Select release needs a few clocks to reach the status
    repeat (4) @(posedge CLK);
    rdc(`IDX_IRQ_STAT, 32'h1800, 32'h1800);
    rdc(`IDX_FLAGS, 32'h3F00_1000, 32'h1000);
    rdc(`IDX_FLAGS, 32'h1000, 32'h0);
    // Fill the transmit side, drain it over the link, then overflow
    wr(`IDX_EVT_EN, 32'h0043);
    for (int i = 0; i < 63; i++) begin
      wr(`IDX_FIFO_HIGH, 32'(i));
      wr(`IDX_FIFO_LOW, 32'hC3C3 ^ 32'(i));
    end
    rdc(`IDX_FLAGS, 32'h003F_0002, 32'h003F_0002);
    for (int i = 0; i < 63; i++) begin
      spi_host_model_i.xfer(32'(i), 32, rx);
      chk(rx, {16'(i), 16'hC3C3 ^ 16'(i)});
    end
    rdc(`IDX_FLAGS, 32'h3F3F_0001, 32'h3F00_0001);
    spi_host_model_i.xfer(32'h0, 32, rx);
    rdc(`IDX_FLAGS, 32'h0040, 32'h0040);
    rdc(`IDX_IRQ_STAT, 32'h0043, 32'h0043);
    clr_stat;
    rdc(`IDX_IRQ_STAT, 32'h8000, 32'h8000);
    finish_test;
  end
endmodule
